// ==== common/fp_cvt_params.svh ====
// constants for the single-precision convert, move and compare unit
`ifndef FP_CVT_PARAMS_SVH
`define FP_CVT_PARAMS_SVH

// =====================================================================
// register map (byte offsets on the plain register port)
`define REG_CONFIG        4'h0
`define REG_FLAGS         4'h4
`define CFG_LONG_BIT      0
`define CFG_RESET         1'b1
`define FLAG_INEXACT_BIT  0
`define FLAG_INVALID_BIT  1

// =====================================================================
// instruction fields
`define FMT_SINGLE        2'h0
`define RM_NEAR_EVEN      3'h0
`define RM_TO_ZERO        3'h1
`define RM_DOWN           3'h2
`define RM_UP             3'h3
`define RM_NEAR_MAX       3'h4

// =====================================================================
// number formats
`define EXP_ALL_ONES      8'hFF
`define EXP_SHIFT_BASE    8'h56
`define EXP_TOO_BIG       8'hBF
`define EXP_INT_TOP       8'hBE
`define CANON_NAN         32'h7FC00000
`define BOX_ONES          32'hFFFFFFFF

// =====================================================================
// magnitude limits after rounding
`define LIM_SW_POS        65'h0_0000_0000_7FFF_FFFF
`define LIM_SW_NEG        65'h0_0000_0000_8000_0000
`define LIM_UW_POS        65'h0_0000_0000_FFFF_FFFF
`define LIM_SL_POS        65'h0_7FFF_FFFF_FFFF_FFFF
`define LIM_SL_NEG        65'h0_8000_0000_0000_0000
`define LIM_UL_POS        65'h0_FFFF_FFFF_FFFF_FFFF
`define SAT_SW_MIN        64'hFFFF_FFFF_8000_0000
`define SAT_SL_MIN        64'h8000_0000_0000_0000

// =====================================================================
// timing: answer follows the request by this many clock edges
`define RESULT_LATENCY    1

`endif

// ==== common/fp_cvt_pkg.sv ====
// types shared by the convert, move and compare unit
package fp_cvt_pkg;

  typedef enum logic [4:0] {
    float_to_signed_word,
    float_to_unsigned_word,
    float_to_signed_long,
    float_to_unsigned_long,
    signed_word_to_float,
    unsigned_word_to_float,
    signed_long_to_float,
    unsigned_long_to_float,
    sign_copy_op,
    sign_negate_op,
    sign_xor_op,
    float_bits_to_integer,
    integer_bits_to_float,
    compare_equal,
    compare_less,
    compare_less_equal
  } fp_op_t;

  typedef struct packed {
    logic        valid;
    fp_op_t      op;
    logic [2:0]  rounding_mode_field;
    logic [1:0]  fmt;
    logic [63:0] float_a;
    logic [63:0] float_b;
    logic [63:0] int_a;
  } fp_req_t;

  typedef struct packed {
    logic invalid;
    logic inexact;
  } fp_flags_t;

  typedef struct packed {
    logic        valid;
    logic        write_int;
    logic        write_float;
    logic        illegal;
    logic [63:0] int_result;
    logic [63:0] float_result;
    fp_flags_t   flags;
  } fp_resp_t;

endpackage

// ==== design/fp_cvt_unit.sv ====
// single-precision convert, sign-inject, move and compare datapath
// Notes on behaviour
// - float converts to signed 32 or 64-bit integer into integer destination
// - signed 32 or 64-bit integer converts to single precision float
// - unsigned variants exist for both conversion directions
// - 32-bit integer results are sign-extended to the 64-bit destination
// - 64-bit conversions only when configured for 64-bit integer registers
// - unrepresentable rounded results saturate and raise invalid
// - range is judged after rounding against the destination limits
// - negative overflow and minus infinity give the type minimum
// - positive overflow gives the type maximum
// - plus infinity or any NaN gives the type maximum
// - every conversion rounds by the rounding mode field
// - converting integer zero gives plus zero with no flags
// - inexact is raised when result differs, unless invalid is raised
// - sign injection copies all bits but the sign from first source
// - sign is second sign, its inverse, or xor of both signs
// - sign injection raises no flags and keeps NaN payloads
// - float bits move to low 32 integer bits unchanged
// - upper 32 integer bits filled with the moved sign bit
// - integer low 32 bits move unchanged into float register
// - compares write 1 when true, 0 otherwise, 0 on any NaN
// - less and less-equal raise invalid on any NaN
// - equal raises invalid only on a signaling NaN
// - every operation must carry the single-precision format code
// - float results have their upper 32 bits set to ones
// - badly boxed operands of non-transfer ops read as canonical NaN
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`include "fp_cvt_params.svh"

module fp_cvt_unit
  import fp_cvt_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  input  wire fp_req_t     req_i,
  output fp_resp_t         resp_o,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_write_i,
  input  wire logic        reg_read_i,
  output logic      [31:0] reg_rdata_o
);

  // ===================================================================
  // helpers
  function automatic logic round_inc(input logic [2:0] rm, input logic sgn,
                                     input logic lsb, input logic r, input logic s);
    unique case (rm)
      `RM_TO_ZERO:  round_inc = 1'b0;
      `RM_DOWN:     round_inc = sgn & (r | s);
      `RM_UP:       round_inc = ~sgn & (r | s);
      `RM_NEAR_MAX: round_inc = r;
      default:      round_inc = r & (s | lsb); // unknown modes round to nearest even
    endcase
  endfunction

  // ===================================================================
  // register state
  logic      long_enable;
  fp_flags_t acc_flags;
  fp_resp_t  next_resp;

  // configuration register: steers the 64-bit conversions
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      long_enable <= `CFG_RESET;
    end else if (reg_write_i && reg_addr_i == `REG_CONFIG) begin
      long_enable <= reg_wdata_i[`CFG_LONG_BIT];
    end
  end

  // accumulated flags, write one to clear; a new flag beats the clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_flags <= '0;
    end else begin
      acc_flags.invalid <= (acc_flags.invalid & ~(reg_write_i && reg_addr_i == `REG_FLAGS
                            && reg_wdata_i[`FLAG_INVALID_BIT]))
                           | (next_resp.valid & next_resp.flags.invalid);
      acc_flags.inexact <= (acc_flags.inexact & ~(reg_write_i && reg_addr_i == `REG_FLAGS
                            && reg_wdata_i[`FLAG_INEXACT_BIT]))
                           | (next_resp.valid & next_resp.flags.inexact);
    end
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      reg_rdata_o <= '0;
    end else if (reg_read_i) begin
      unique case (reg_addr_i)
        `REG_CONFIG: reg_rdata_o <= {31'h0, long_enable};
        `REG_FLAGS:  reg_rdata_o <= {30'h0, acc_flags.invalid, acc_flags.inexact};
        default:     reg_rdata_o <= '0;
      endcase
    end else begin
      reg_rdata_o <= '0;
    end
  end

  // ===================================================================
  // operand unboxing for non-transfer operations
  logic [31:0] fa;
  logic [31:0] fb;
  logic        a_nan;
  logic        b_nan;
  logic        a_snan;
  logic        b_snan;

  always_comb begin
    fa = (req_i.float_a[63:32] == `BOX_ONES) ? req_i.float_a[31:0] : `CANON_NAN;
    fb = (req_i.float_b[63:32] == `BOX_ONES) ? req_i.float_b[31:0] : `CANON_NAN;
    a_nan  = (fa[30:23] == `EXP_ALL_ONES) && (fa[22:0] != 23'h0);
    b_nan  = (fb[30:23] == `EXP_ALL_ONES) && (fb[22:0] != 23'h0);
    a_snan = a_nan & ~fa[22];
    b_snan = b_nan & ~fb[22];
  end

  // ===================================================================
  // float to integer
  logic [127:0] wide;
  logic [64:0]  f2i_mag;
  logic [64:0]  lim_pos;
  logic [64:0]  lim_neg;
  logic [63:0]  f2i_out;
  logic         f2i_inv;
  logic         f2i_inx;

  // the significand is placed in a 64.64 fixed-point field; tiny values
  // skip the shifter entirely since they can only feed the sticky bit
  always_comb begin
    logic [63:0] value;
    logic        rbit;
    logic        sbit;
    logic        tiny;
    logic        huge;
    logic        is_word;
    logic        is_signed;
    // defined first: no latch on any path
    value     = '0;
    rbit      = 1'b0;
    sbit      = 1'b0;
    is_word   = 1'b0;
    is_signed = 1'b0;

    tiny      = fa[30:23] < `EXP_SHIFT_BASE;
    huge      = fa[30:23] >= `EXP_TOO_BIG;
    wide      = '0;
    if (!tiny) begin
      wide = {104'h0, |fa[30:23], fa[22:0]} << (fa[30:23] - `EXP_SHIFT_BASE);
    end
    rbit      = wide[63];
    sbit      = |wide[62:0] | (tiny & |fa[30:0]);
    f2i_mag   = {1'b0, wide[127:64]}
              + 65'(round_inc(req_i.rounding_mode_field, fa[31], wide[64], rbit, sbit));
    is_word   = (req_i.op == float_to_signed_word) || (req_i.op == float_to_unsigned_word);
    is_signed = (req_i.op == float_to_signed_word) || (req_i.op == float_to_signed_long);
    unique case ({is_word, is_signed})
      2'b11:   begin lim_pos = `LIM_SW_POS; lim_neg = `LIM_SW_NEG; end
      2'b10:   begin lim_pos = `LIM_UW_POS; lim_neg = '0; end
      2'b01:   begin lim_pos = `LIM_SL_POS; lim_neg = `LIM_SL_NEG; end
      default: begin lim_pos = `LIM_UL_POS; lim_neg = '0; end
    endcase
    // range judged on the rounded magnitude
    f2i_inv = a_nan | huge | (fa[31] ? (f2i_mag > lim_neg) : (f2i_mag > lim_pos));
    if (f2i_inv && (a_nan || !fa[31])) begin
      value = lim_pos[63:0];
    end else if (f2i_inv) begin
      value = !is_signed ? 64'h0 : (is_word ? `SAT_SW_MIN : `SAT_SL_MIN);
    end else begin
      value = fa[31] ? (64'h0 - f2i_mag[63:0]) : f2i_mag[63:0];
    end
    f2i_out = is_word ? {{32{value[31]}}, value[31:0]} : value;
    f2i_inx = ~f2i_inv & (rbit | sbit);
  end

  // ===================================================================
  // integer to float
  logic [31:0] i2f_out;
  logic        i2f_inx;

  always_comb begin
    logic [63:0] src;
    logic [63:0] mag;
    logic [63:0] norm;
    logic [5:0]  lz;
    logic [23:0] man;
    logic [7:0]  ex;
    logic        neg;
    logic        rbit;
    logic        sbit;
    // every local defined up front
    src  = '0;
    mag  = '0;
    norm = '0;
    lz   = '0;
    man  = '0;
    ex   = '0;
    neg  = 1'b0;
    rbit = 1'b0;
    sbit = 1'b0;

    unique case (req_i.op)
      signed_word_to_float:   src = {{32{req_i.int_a[31]}}, req_i.int_a[31:0]};
      unsigned_word_to_float: src = {32'h0, req_i.int_a[31:0]};
      default:                src = req_i.int_a;
    endcase
    neg = src[63] && (req_i.op == signed_word_to_float || req_i.op == signed_long_to_float);
    mag = neg ? (64'h0 - src) : src;
    lz  = '0;
    for (int i = 0; i < 64; i++) begin
      if (mag[i]) begin
        lz = 6'(63 - i);
      end
    end
    norm = mag << lz;
    rbit = norm[39];
    sbit = |norm[38:0];
    man  = {1'b0, norm[62:40]}
         + 24'(round_inc(req_i.rounding_mode_field, neg, norm[40], rbit, sbit));
    ex   = `EXP_INT_TOP - 8'(lz) + 8'(man[23]);
    // zero source, including the hard-wired zero register, gives plus zero
    i2f_out = (mag == 64'h0) ? 32'h0 : {neg, ex, man[22:0]};
    i2f_inx = rbit | sbit;
  end

  // ===================================================================
  // compares on unboxed operands
  logic feq;
  logic flt;

  always_comb begin
    logic both_zero;
    both_zero = (fa[30:0] == 31'h0) && (fb[30:0] == 31'h0);
    feq = ~a_nan & ~b_nan & ((fa == fb) | both_zero);
    if (a_nan || b_nan || both_zero) begin
      flt = 1'b0;
    end else if (fa[31] != fb[31]) begin
      flt = fa[31];
    end else begin
      flt = fa[31] ? (fa[30:0] > fb[30:0]) : (fa[30:0] < fb[30:0]);
    end
  end

  // ===================================================================
  // operation select
  always_comb begin
    logic long_op;
    long_op = (req_i.op == float_to_signed_long) || (req_i.op == float_to_unsigned_long)
           || (req_i.op == signed_long_to_float) || (req_i.op == unsigned_long_to_float);
    next_resp       = '0;
    next_resp.valid = req_i.valid;
    if ((req_i.fmt != `FMT_SINGLE) || (long_op && !long_enable)) begin
      next_resp.illegal = req_i.valid;
    end else begin
      unique case (req_i.op)
        float_to_signed_word, float_to_unsigned_word,
        float_to_signed_long, float_to_unsigned_long: begin
          next_resp.write_int     = 1'b1;
          next_resp.int_result    = f2i_out;
          next_resp.flags.invalid = f2i_inv;
          next_resp.flags.inexact = f2i_inx;
        end
        signed_word_to_float, unsigned_word_to_float,
        signed_long_to_float, unsigned_long_to_float: begin
          next_resp.write_float   = 1'b1;
          next_resp.float_result  = {`BOX_ONES, i2f_out};
          next_resp.flags.inexact = i2f_inx;
        end
        sign_copy_op, sign_negate_op, sign_xor_op: begin
          next_resp.write_float  = 1'b1;
          next_resp.float_result = {`BOX_ONES,
            (req_i.op == sign_copy_op)   ? fb[31] :
            (req_i.op == sign_negate_op) ? ~fb[31] : (fa[31] ^ fb[31]),
            fa[30:0]};
        end
        float_bits_to_integer: begin
          next_resp.write_int  = 1'b1;
          next_resp.int_result = {{32{req_i.float_a[31]}}, req_i.float_a[31:0]};
        end
        integer_bits_to_float: begin
          next_resp.write_float  = 1'b1;
          next_resp.float_result = {`BOX_ONES, req_i.int_a[31:0]};
        end
        compare_equal: begin
          next_resp.write_int     = 1'b1;
          next_resp.int_result    = {63'h0, feq};
          next_resp.flags.invalid = a_snan | b_snan;
        end
        compare_less, compare_less_equal: begin
          next_resp.write_int     = 1'b1;
          next_resp.int_result    = {63'h0, flt | ((req_i.op == compare_less_equal) & feq)};
          next_resp.flags.invalid = a_nan | b_nan;
        end
        default: next_resp.illegal = req_i.valid; // unused operation codes
      endcase
    end
    if (!req_i.valid) begin
      next_resp = '0;
    end
  end

  // answer registered one cycle after the request
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      resp_o <= '0;
    end else begin
      resp_o <= next_resp;
    end
  end

  // ===================================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  chk_sign_no_flags: assert property (
    $past(req_i.valid && req_i.fmt == `FMT_SINGLE && req_i.op inside {sign_copy_op,
      sign_negate_op, sign_xor_op}) |-> resp_o.flags == '0 && resp_o.write_float)
    else $error("sign injection raised a flag");
  chk_cmp_nan_zero: assert property (
    $past(req_i.valid && req_i.fmt == `FMT_SINGLE && (a_nan || b_nan) && req_i.op inside
      {compare_equal, compare_less, compare_less_equal}) |-> resp_o.int_result == 64'h0)
    else $error("compare with NaN did not give zero");
  chk_less_invalid: assert property (
    $past(req_i.valid && req_i.fmt == `FMT_SINGLE && (a_nan || b_nan)
      && req_i.op inside {compare_less, compare_less_equal}) |-> resp_o.flags.invalid)
    else $error("signaling compare missed invalid");
  chk_eq_quiet: assert property (
    $past(req_i.valid && req_i.fmt == `FMT_SINGLE && req_i.op == compare_equal
      && !a_snan && !b_snan) |-> !resp_o.flags.invalid)
    else $error("quiet compare raised invalid");
  chk_move_sext: assert property (
    $past(req_i.valid && req_i.fmt == `FMT_SINGLE && req_i.op == float_bits_to_integer)
    |-> resp_o.int_result == {{32{$past(req_i.float_a[31])}}, $past(req_i.float_a[31:0])})
    else $error("bit move to integer altered bits");
  chk_box_upper: assert property (
    resp_o.write_float |-> resp_o.float_result[63:32] == `BOX_ONES)
    else $error("float result not boxed");
  chk_flag_excl: assert property (
    resp_o.valid |-> !(resp_o.flags.invalid && resp_o.flags.inexact))
    else $error("inexact raised beside invalid");
  chk_zero_plain: assert property (
    $past(req_i.valid && req_i.fmt == `FMT_SINGLE && req_i.int_a == 64'h0
      && req_i.op == signed_word_to_float) |-> resp_o.float_result[31:0] == 32'h0
      && resp_o.flags == '0)
    else $error("zero conversion not plain zero");
  chk_word_sext: assert property (
    ##1 $past(req_i.valid && req_i.op inside {float_to_signed_word, float_to_unsigned_word})
    && resp_o.write_int |-> resp_o.int_result[63:32] == {32{resp_o.int_result[31]}})
    else $error("word result not sign-extended");
  chk_long_gate: assert property (
    !long_enable && req_i.valid && req_i.op == float_to_signed_long
    |=> resp_o.illegal && !resp_o.write_int)
    else $error("long conversion ran while disabled");
  chk_flag_sticky: assert property (
    resp_o.valid && resp_o.flags.invalid |-> acc_flags.invalid)
    else $error("invalid flag not accumulated");
  chk_rdata_idle: assert property (
    !$past(reg_read_i) |-> reg_rdata_o == '0)
    else $error("read data stood outside the read cycle");

  cov_f2i_sat: cover property (resp_o.valid && resp_o.write_int && resp_o.flags.invalid);
  cov_i2f_inexact: cover property (resp_o.write_float && resp_o.flags.inexact);
  cov_cmp_true: cover property (resp_o.write_int && resp_o.int_result == 64'h1);
  // refused requests and word saturation
  cov_refused: cover property (resp_o.illegal);
  cov_word_sat: cover property (resp_o.int_result == 64'h7FFF_FFFF);

endmodule

// ==== verification/core_model.sv ====
// core-side partner model: issues requests and accumulates raised flags
`timescale 1ns/1ps

module core_model
  import fp_cvt_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     reset_i,
  input  wire fp_resp_t resp_i,
  output fp_req_t       req_o,
  output fp_flags_t     acc_o
);

  // =====================================================================
  // request driver
  // nothing is requested until reset has been released
  initial begin
    req_o = '0;
  end

  // one request, held to its taking edge, answer sampled after that edge
  task automatic issue(input fp_op_t op, input logic [2:0] rm, input logic [1:0] fmt,
                       input logic [63:0] a, input logic [63:0] b, input logic [63:0] ia,
                       output fp_resp_t r);
    @(posedge clk_i);
    req_o <= '{valid: 1'b1, op: op, rounding_mode_field: rm, fmt: fmt,
               float_a: a, float_b: b, int_a: ia};
    @(posedge clk_i);
    // released operands are inverted so a stale value cannot pass as a match
    req_o <= fp_req_t'({1'b0, ~req_o[$bits(fp_req_t)-2:0]});
    #1 r = resp_i;
  endtask

  // =====================================================================
  // software-visible flag accumulation in the core
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      acc_o <= '0;
    end else if (resp_i.valid) begin
      acc_o <= acc_o | resp_i.flags;
    end
  end

endmodule

// ==== verification/testbench.sv ====
// self-checking bench for the convert, move and compare unit
`timescale 1ns/1ps
`include "fp_cvt_params.svh"

module testbench
  import fp_cvt_pkg::*;
;
  logic        clk_i;
  logic        reset_i;
  fp_req_t     req;
  fp_resp_t    resp;
  fp_flags_t   acc;
  fp_resp_t    r;
  logic [3:0]  reg_addr_i;
  logic [31:0] reg_wdata_i;
  logic        reg_write_i;
  logic        reg_read_i;
  logic [31:0] reg_rdata_o;
  logic [31:0] rd;
  logic [31:0] a32;
  logic [31:0] b32;
  logic [63:0] i64;
  int          mismatches;
  int          comparisons;
  int          cycles;
  int          seed_dummy;

  fp_cvt_unit u_dut (.clk_i(clk_i), .reset_i(reset_i), .req_i(req), .resp_o(resp),
                     .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
                     .reg_write_i(reg_write_i), .reg_read_i(reg_read_i),
                     .reg_rdata_o(reg_rdata_o));
  core_model u_core (.clk_i(clk_i), .reset_i(reset_i), .resp_i(resp), .req_o(req),
                     .acc_o(acc));

  // =====================================================================
  // clock and timeout
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // a hang counts as a mismatch and ends the run
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      mismatches = mismatches + 1;
      results();
    end
  end

  // =====================================================================
  // helpers
  function automatic logic [63:0] box(input logic [31:0] v);
    return {`BOX_ONES, v};
  endfunction

  function automatic logic [31:0] sgn(input fp_op_t op, input logic [31:0] a,
                                      input logic [31:0] b);
    case (op)
      sign_copy_op:   return {b[31], a[30:0]};
      sign_negate_op: return {~b[31], a[30:0]};
      default:        return {a[31] ^ b[31], a[30:0]};
    endcase
  endfunction

  task automatic check(input logic [63:0] got, input logic [63:0] exp);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // register port: one-cycle strobes, read data in the following cycle
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    reg_write_i <= 1'b1;
    @(posedge clk_i);
    reg_write_i <= 1'b0;
    reg_wdata_i <= ~d;
  endtask

  task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_i);
    reg_addr_i <= a;
    reg_read_i <= 1'b1;
    @(posedge clk_i);
    reg_read_i <= 1'b0;
    #1 d = reg_rdata_o;
  endtask

  // float to integer with expected integer and {invalid,inexact}
  task automatic fi(input fp_op_t op, input logic [2:0] rm, input logic [31:0] a,
                    input logic [63:0] exp, input logic [1:0] fl);
    u_core.issue(op, rm, `FMT_SINGLE, box(a), box(~a), 64'h0, r);
    check({r.valid, r.write_int, r.write_float}, 3'b110);
    check(r.int_result, exp);
    check(r.flags, fl);
  endtask

  // integer to float with expected single and flags
  task automatic itf(input fp_op_t op, input logic [2:0] rm, input logic [63:0] ia,
                     input logic [31:0] exp, input logic [1:0] fl);
    u_core.issue(op, rm, `FMT_SINGLE, 64'h0, 64'h0, ia, r);
    check({r.valid, r.write_int, r.write_float}, 3'b101);
    check(r.float_result, box(exp));
    check(r.flags, fl);
  endtask

  task automatic cmp(input fp_op_t op, input logic [31:0] a, input logic [31:0] b,
                     input logic exp, input logic [1:0] fl);
    u_core.issue(op, `RM_NEAR_EVEN, `FMT_SINGLE, box(a), box(b), 64'h0, r);
    check({r.valid, r.write_int, r.write_float}, 3'b110);
    check(r.int_result, {63'h0, exp});
    check(r.flags, fl);
  endtask

  // =====================================================================
  // main sequence
  initial begin
    seed_dummy = $urandom(32'h09FBC545);
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    reset_i = 1'b1;
    reg_addr_i = 4'h0;
    reg_wdata_i = 32'h0;
    reg_write_i = 1'b0;
    reg_read_i = 1'b0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    // reset values and an unmapped place
    reg_rd(`REG_CONFIG, rd);
    check(rd, 32'h1);
    reg_rd(`REG_FLAGS, rd);
    check(rd, 32'h0);
    reg_wr(4'h8, 32'hFFFFFFFF);
    reg_rd(4'h8, rd);
    check(rd, 32'h0);
    // every rounding mode, on 2.5 except round-down on -2.5
    fi(float_to_signed_word, `RM_NEAR_EVEN, 32'h40200000, 64'h2, 2'b01);
    fi(float_to_signed_word, `RM_TO_ZERO, 32'h40200000, 64'h2, 2'b01);
    fi(float_to_signed_word, `RM_DOWN, 32'hC0200000, 64'hFFFF_FFFF_FFFF_FFFD, 2'b01);
    fi(float_to_signed_word, `RM_UP, 32'h40200000, 64'h3, 2'b01);
    fi(float_to_signed_word, `RM_NEAR_MAX, 32'h40200000, 64'h3, 2'b01);
    // range limits judged after rounding, saturation
    fi(float_to_signed_word, `RM_NEAR_EVEN, 32'hCF000000, `SAT_SW_MIN, 2'b00);
    fi(float_to_signed_word, `RM_NEAR_EVEN, 32'h4F000000, 64'h7FFF_FFFF, 2'b10);
    fi(float_to_signed_word, `RM_NEAR_EVEN, 32'hFF800000, `SAT_SW_MIN, 2'b10);
    fi(float_to_unsigned_word, `RM_NEAR_EVEN, 32'hBF000000, 64'h0, 2'b01);
    fi(float_to_unsigned_word, `RM_DOWN, 32'hBF000000, 64'h0, 2'b10);
    fi(float_to_unsigned_word, `RM_NEAR_EVEN, 32'h4F000000, 64'hFFFF_FFFF_8000_0000, 2'b00);
    fi(float_to_unsigned_word, `RM_NEAR_EVEN, 32'h7F800001, 64'hFFFF_FFFF_FFFF_FFFF, 2'b10);
    fi(float_to_signed_long, `RM_NEAR_EVEN, 32'h5F000000, 64'(`LIM_SL_POS), 2'b10);
    fi(float_to_signed_long, `RM_NEAR_EVEN, 32'hFF800000, `SAT_SL_MIN, 2'b10);
    fi(float_to_signed_long, `RM_TO_ZERO, 32'hBFC00000, 64'hFFFF_FFFF_FFFF_FFFF, 2'b01);
    fi(float_to_unsigned_long, `RM_NEAR_EVEN, 32'h5F000000, 64'h8000_0000_0000_0000, 2'b00);
    fi(float_to_unsigned_long, `RM_NEAR_EVEN, 32'h7FC00000, 64'(`LIM_UL_POS), 2'b10);
    fi(float_to_unsigned_long, `RM_NEAR_EVEN, 32'hBF800000, 64'h0, 2'b10);
    check(acc, 2'b11);
    reg_rd(`REG_FLAGS, rd);
    check(rd, 32'h3);
    reg_wr(`REG_FLAGS, 32'h3);
    reg_rd(`REG_FLAGS, rd);
    check(rd, 32'h0);
    // integer to float
    itf(signed_word_to_float, `RM_NEAR_EVEN, 64'h0, 32'h0, 2'b00);
    itf(signed_word_to_float, `RM_NEAR_EVEN, 64'hFFFF_FFFF, 32'hBF800000, 2'b00);
    itf(signed_word_to_float, `RM_NEAR_EVEN, 64'h0100_0001, 32'h4B800000, 2'b01);
    itf(signed_word_to_float, `RM_UP, 64'h0100_0001, 32'h4B800001, 2'b01);
    itf(unsigned_word_to_float, `RM_NEAR_EVEN, 64'hFFFF_FFFF, 32'h4F800000, 2'b01);
    itf(unsigned_word_to_float, `RM_TO_ZERO, 64'hFFFF_FFFF, 32'h4F7FFFFF, 2'b01);
    itf(signed_long_to_float, `RM_NEAR_EVEN, `SAT_SL_MIN, 32'hDF000000, 2'b00);
    itf(unsigned_long_to_float, `RM_DOWN, `LIM_UL_POS, 32'h5F7FFFFF, 2'b01);
    // random sign injection and bit moves, payloads untouched
    repeat (8) begin
      a32 = $urandom();
      b32 = $urandom();
      i64 = {$urandom(), $urandom()};
      for (int k = 0; k < 3; k++) begin
        u_core.issue(fp_op_t'(int'(sign_copy_op) + k), `RM_NEAR_EVEN, `FMT_SINGLE,
                     box(a32), box(b32), 64'h0, r);
        check(r.float_result, box(sgn(fp_op_t'(int'(sign_copy_op) + k), a32, b32)));
        check({r.write_float, r.flags}, 3'b100);
      end
      u_core.issue(float_bits_to_integer, `RM_NEAR_EVEN, `FMT_SINGLE, i64, 64'h0, 64'h0, r);
      check(r.int_result, {{32{i64[31]}}, i64[31:0]});
      u_core.issue(integer_bits_to_float, `RM_NEAR_EVEN, `FMT_SINGLE, 64'h0, 64'h0, i64, r);
      check(r.float_result, box(i64[31:0]));
    end
    // a badly boxed first source reads as the canonical NaN
    u_core.issue(sign_negate_op, `RM_NEAR_EVEN, `FMT_SINGLE, 64'h1, box(32'h0), 64'h0, r);
    check(r.float_result, box(`CANON_NAN | 32'h80000000));
    check(r.flags, 2'b00);
    // compares
    cmp(compare_equal, 32'h3F800000, 32'h3F800000, 1'b1, 2'b00);
    cmp(compare_equal, 32'h80000000, 32'h00000000, 1'b1, 2'b00);
    cmp(compare_less, 32'hBF800000, 32'h3F800000, 1'b1, 2'b00);
    cmp(compare_less, 32'h40000000, 32'h3F800000, 1'b0, 2'b00);
    cmp(compare_less_equal, 32'h3F800000, 32'h3F800000, 1'b1, 2'b00);
    cmp(compare_less_equal, 32'h7FC00000, 32'h3F800000, 1'b0, 2'b10);
    cmp(compare_less, 32'h3F800000, 32'h7F800001, 1'b0, 2'b10);
    cmp(compare_equal, 32'h7FC00000, 32'h7FC00000, 1'b0, 2'b00);
    cmp(compare_equal, 32'h7F800001, 32'h3F800000, 1'b0, 2'b10);
    @(posedge clk_i);
    #1 check(64'(resp != '0), 64'h0);
    // refused: wrong format, then long ops with long support off
    u_core.issue(sign_copy_op, `RM_NEAR_EVEN, 2'h1, box(32'h0), box(32'h0), 64'h0, r);
    check({r.valid, r.illegal, r.write_int, r.write_float, r.flags}, 6'b110000);
    reg_wr(`REG_CONFIG, 32'h0);
    reg_rd(`REG_CONFIG, rd);
    check(rd, 32'h0);
    u_core.issue(float_to_signed_long, `RM_NEAR_EVEN, `FMT_SINGLE, box(32'hFF800000), 64'h0,
                 64'h0, r);
    check({r.valid, r.illegal, r.write_int, r.write_float, r.flags}, 6'b110000);
    u_core.issue(unsigned_long_to_float, `RM_NEAR_EVEN, `FMT_SINGLE, 64'h0, 64'h0, 64'h5, r);
    check({r.illegal, r.write_float}, 2'b10);
    reg_wr(`REG_CONFIG, 32'h1);
    fi(float_to_signed_long, `RM_NEAR_EVEN, 32'h40200000, 64'h2, 2'b01);
    results();
  end

endmodule
